// *** dacc_track.sv ***
// Functional notes
// - Ten accumulators of ten positions each.
// - Positions numbered like any other track.
// - Ten digits each, never chained together.
// - Result beyond ten digits sets overflow.
// - Adjacent fields enter adjacent accumulators.
// - Codes select add, subtract, readout, reset.
// - Destination position sets digit alignment.
// - Control five clears target before entry.
// - Reset-add takes no extra time.
// - Plain readout leaves accumulator unchanged.
// - Readout-reset clears every touched accumulator.
// - Negative values kept in tens complement.
// - Negative readout gives magnitude plus sign.
// - Conversion on readout adds no time.
// - Overflow latches until dropped, lamp too.
// - Negative operand reverses add and subtract.
// - Each accumulator reports plus, zero, minus.
// - Only numeric part of characters kept.
module dacc_track (
   input wire logic i_clock,
   input wire logic i_rstn,
   // AHB-Lite slave port.
   input wire logic i_hsel,
   input wire logic [7:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // Instruction sequencer side.
   input wire logic i_start,
   input wire logic [1:0] i_op,
   input wire logic i_reset_first,
   input wire logic [6:0] i_pos,
   input wire logic i_char_valid,
   input wire logic [3:0] i_char_digit,
   input wire logic i_char_neg,
   input wire logic i_end,
   input wire logic i_overflow_drop,
   output logic o_rd_valid,
   output logic [3:0] o_rd_digit,
   output logic o_rd_neg,
   output logic o_busy,
   output logic o_overflow,
   output logic [9:0] o_acc_neg,
   output logic [9:0] o_acc_zero,
   output logic o_irq
);

   // ********
   // Helper functions.
   // ********

   // Accumulator that owns a track position.
   function automatic logic [3:0] acc_of(input logic [6:0] p);
      acc_of = 4'(p / 7'd10);
   endfunction

   // Digit weight of a track position inside its accumulator.
   function automatic logic [3:0] wt_of(input logic [6:0] p);
      wt_of = dacc_pkg::UNITS_IDX - 4'(p % 7'd10);
   endfunction

   // Nines complement of a working word, digit by digit.
   function automatic logic [43:0] nines(input logic [43:0] x);
      logic [43:0] r;
      r = 44'h000_0000_0000;
      for (int i = 0; i < dacc_pkg::WORK_DIGITS; i++) begin
         r[4*i+:4] = 4'h9 - x[4*i+:4];
      end
      nines = r;
   endfunction

   // ********
   // State.
   // ********

   // Ten sections of ten digits, units digit held in the low nibble.
   logic [39:0] acc_reg [0:9];
   logic [39:0] acc_next;
   // Sign of each accumulator, set while it holds a tens complement.
   logic [9:0] neg_reg;
   logic [9:0] neg_next;
   // Accumulators already reached by the running instruction.
   logic [9:0] touched_reg;
   // Sign of the field entering each accumulator.
   logic [9:0] fneg_reg;
   // Sequencer state, operation and current position.
   dacc_pkg::dacc_state_t state_reg;
   logic [1:0] op_reg;
   logic rfirst_reg;
   logic [6:0] pos_reg;
   // Overflow latch and the interrupt registers.
   logic ovf_reg;
   logic [1:0] status_reg;
   logic [1:0] int_en_reg;
   // Pending bus write, captured in the address phase.
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;

   // ********
   // Position decode of the current character.
   // ********

   // The position is plain track numbering, split by fixed division.
   wire [3:0] cur_acc = acc_of(pos_reg);
   wire [3:0] cur_wt = wt_of(pos_reg);
   wire first_in = ~touched_reg[cur_acc];
   wire [39:0] cur_val = acc_reg[cur_acc];
   wire cur_neg = neg_reg[cur_acc];
   // The first character into an accumulator carries the field sign.
   wire field_neg = first_in ? i_char_neg : fneg_reg[cur_acc];
   // Destination codes pick the direction, the field sign flips it.
   wire do_sub = (op_reg == dacc_pkg::OP_SUB) ^ field_neg;
   // A reset-first entry starts its accumulator from zero.
   wire base_zero = rfirst_reg & first_in;
   wire [43:0] base_word = base_zero ? 44'h000_0000_0000
                           : {cur_neg ? dacc_pkg::SIGN_NEG : dacc_pkg::SIGN_POS, cur_val};
   // The digit lands at the weight of the destination position.
   // Only the numeric nibble of the character is used.
   wire [43:0] opnd_word = 44'(i_char_digit) << (4 * cur_wt);
   wire [43:0] addend = do_sub ? nines(opnd_word) : opnd_word;
   wire [43:0] sum_word;

   // Signed sum in tens complement with a sign digit on top.
   dacc_bcd_add #(
      .DIGITS(dacc_pkg::WORK_DIGITS)
   ) u_sum (
      .i_a(base_word),
      .i_b(addend),
      .i_cin(do_sub),
      .o_sum(sum_word),
      .o_cout()
   );

   // Each section adds alone, ten digits wide.
   // The carry out of the top digit is dropped, never passed on.
   wire [3:0] sum_sign = sum_word[43:40];
   // A sign digit other than plus or minus means more than ten digits.
   wire sum_ovf = ((sum_sign != dacc_pkg::SIGN_POS) && (sum_sign != dacc_pkg::SIGN_NEG))
                  || ((sum_sign == dacc_pkg::SIGN_NEG) && (sum_word[39:0] == 40'h00_0000_0000));

   // ********
   // Magnitude for readout.
   // ********

   wire [43:0] mag_word;

   // Conversion is combinational, so readout keeps its pace.
   dacc_bcd_add #(
      .DIGITS(dacc_pkg::WORK_DIGITS)
   ) u_mag (
      .i_a((cur_neg ? nines({4'h0, cur_val}) : {4'h0, cur_val}) & 44'h0FF_FFFF_FFFF),
      .i_b(44'h000_0000_0000),
      .i_cin(cur_neg),
      .o_sum(mag_word),
      .o_cout()
   );

   // True digit at the read position.
   wire [3:0] mag_digit = mag_word[4*cur_wt+:4];

   // ********
   // Control decode.
   // ********

   wire in_enter = (state_reg == dacc_pkg::DACC_ENTER);
   wire in_read = (state_reg == dacc_pkg::DACC_READ);
   wire enter_char = in_enter & i_char_valid;
   wire read_char = in_read & i_char_valid;
   wire start_ok = (state_reg == dacc_pkg::DACC_IDLE) & i_start;
   wire finish = (state_reg != dacc_pkg::DACC_IDLE) & i_end;
   // Readout-reset clears whole accumulators at the end.
   wire clear_touched = finish & in_read & (op_reg == dacc_pkg::OP_READ_RESET);
   wire ovf_event = enter_char & sum_ovf;
   // Next position, wrapping from the first to the last on the track.
   wire [6:0] pos_dec = (pos_reg == 7'd0) ? 7'(dacc_pkg::TRACK_POS - 1) : pos_reg - 7'd1;

   // Value written back by an entering character.
   assign acc_next = sum_word[39:0];
   assign neg_next = (neg_reg & ~(10'h001 << cur_acc))
                     | ({9'h000, sum_sign == dacc_pkg::SIGN_NEG} << cur_acc);

   // ********
   // Bus decode.
   // ********

   wire bus_take = i_hsel & i_htrans[1] & i_hready;
   wire wr_take = bus_take & i_hwrite;
   wire wr_ctrl = wr_pend_reg & (wr_addr_reg == dacc_pkg::ADDR_CTRL);
   wire wr_clr = wr_pend_reg & (wr_addr_reg == dacc_pkg::ADDR_INT_CLR);
   wire wr_en = wr_pend_reg & (wr_addr_reg == dacc_pkg::ADDR_INT_EN);
   wire drop_req = i_overflow_drop | (wr_ctrl & i_hwdata[dacc_pkg::CTRL_DROP]);
   wire [1:0] ev_set = {finish, ovf_event};
   wire [1:0] ev_clr = wr_clr ? i_hwdata[1:0] : 2'h0;

   // Sign register image, also driving the panel outputs.
   wire [9:0] zero_now;
   wire [31:0] sign_word = {10'h000, state_reg != dacc_pkg::DACC_IDLE, ovf_reg,
                            zero_now, neg_reg};

   // Zero flag per accumulator, beside its sign.
   genvar g;
   generate
      for (g = 0; g < dacc_pkg::NUM_ACC; g = g + 1) begin : g_zero
         assign zero_now[g] = (acc_reg[g] == dacc_pkg::ACC_RESET);
      end
   endgenerate

   // Read data mux; unmapped and write-only words read as zero.
   wire [31:0] rd_mux = (i_haddr == dacc_pkg::ADDR_STATUS) ? {30'h0000_0000, status_reg}
                      : (i_haddr == dacc_pkg::ADDR_INT_EN) ? {30'h0000_0000, int_en_reg}
                      : (i_haddr == dacc_pkg::ADDR_SIGN) ? sign_word
                      : 32'h0000_0000;

   // ********
   // Sequencer.
   // ********

   // Instruction start, operation capture and end.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= dacc_pkg::DACC_IDLE;
         op_reg <= dacc_pkg::OP_ADD;
         rfirst_reg <= 1'b0;
      end else if (start_ok) begin
         // Source codes read, destination codes enter.
         op_reg <= i_op;
         rfirst_reg <= i_reset_first;
         state_reg <= i_op[1] ? dacc_pkg::DACC_READ : dacc_pkg::DACC_ENTER;
      end else if (finish) begin
         state_reg <= dacc_pkg::DACC_IDLE;
      end
   end

   // Position walks from the low-order end toward the high-order end.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         pos_reg <= 7'd0;
      end else if (start_ok) begin
         pos_reg <= i_pos;
      end else if (enter_char | read_char) begin
         // Crossing ten positions steps into the next accumulator.
         pos_reg <= pos_dec;
      end
   end

   // Accumulators reached, with the sign of the field entering each.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         touched_reg <= 10'h000;
         fneg_reg <= 10'h000;
      end else if (start_ok) begin
         touched_reg <= 10'h000;
      end else if ((enter_char | read_char) & first_in) begin
         touched_reg[cur_acc] <= 1'b1;
         fneg_reg[cur_acc] <= i_char_neg;
      end
   end

   // ********
   // Accumulator storage.
   // ********

   // Entering characters update one accumulator; readout-reset clears.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int i = 0; i < dacc_pkg::NUM_ACC; i++) begin
            acc_reg[i] <= dacc_pkg::ACC_RESET;
         end
         neg_reg <= 10'h000;
      end else if (enter_char) begin
         // Reset and entry share one cycle per character.
         acc_reg[cur_acc] <= acc_next;
         neg_reg <= neg_next;
      end else if (clear_touched) begin
         for (int i = 0; i < dacc_pkg::NUM_ACC; i++) begin
            if (touched_reg[i]) begin
               acc_reg[i] <= dacc_pkg::ACC_RESET;
            end
         end
         neg_reg <= neg_reg & ~touched_reg;
      end
   end

   // ********
   // Readout path.
   // ********

   // Plain readout only drives the outputs, storage stays as it was.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rd_valid <= 1'b0;
         o_rd_digit <= 4'h0;
         o_rd_neg <= 1'b0;
      end else begin
         o_rd_valid <= read_char;
         o_rd_digit <= read_char ? mag_digit : 4'h0;
         // Sign mark on the first digit out of a negative one.
         o_rd_neg <= read_char & cur_neg & first_in;
      end
   end

   // ********
   // Overflow latch and panel outputs.
   // ********

   // The latch holds until dropped; a new overflow beats the drop.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         ovf_reg <= 1'b0;
      end else if (ovf_event) begin
         ovf_reg <= 1'b1;
      end else if (drop_req) begin
         ovf_reg <= 1'b0;
      end
   end

   // Registered copies for the lamp, sign selectors and busy line.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_overflow <= 1'b0;
         o_acc_neg <= 10'h000;
         o_acc_zero <= 10'h3FF;
         o_busy <= 1'b0;
      end else begin
         // The console lamp follows the latch.
         o_overflow <= ovf_reg;
         // Plus, zero and minus per accumulator.
         o_acc_neg <= neg_reg;
         o_acc_zero <= zero_now;
         o_busy <= (state_reg != dacc_pkg::DACC_IDLE);
      end
   end

   // ********
   // Interrupt registers.
   // ********

   // Sticky events; a set in the same cycle as its clear wins.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         status_reg <= 2'h0;
         int_en_reg <= dacc_pkg::INT_EN_RESET;
         o_irq <= 1'b0;
      end else begin
         status_reg <= (status_reg & ~ev_clr) | ev_set;
         if (wr_en) begin
            int_en_reg <= i_hwdata[1:0];
         end
         o_irq <= |(status_reg & int_en_reg);
      end
   end

   // ********
   // AHB-Lite slave.
   // ********

   // Zero-wait slave: read data is registered during the address phase.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         o_hrdata <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         wr_pend_reg <= wr_take;
         wr_addr_reg <= i_haddr;
         if (bus_take & ~i_hwrite) begin
            o_hrdata <= rd_mux;
         end
      end
   end

endmodule

// *** dacc_pkg.sv ***
// ********
// Shared constants of the decimal accumulator track.
// ********
package dacc_pkg;

   // ********
   // Track geometry.
   // ********
   // Accumulators on the track, and digit positions in each one.
   localparam int NUM_ACC = 10;
   localparam int ACC_DIGITS = 10;
   // Positions on the track, numbered like every other track.
   localparam int TRACK_POS = 100;
   // Position index of the units digit inside a ten-position section.
   localparam logic [3:0] UNITS_IDX = 4'h9;
   // Digits of the signed working word: ten digits plus a sign digit.
   localparam int WORK_DIGITS = 11;
   // Sign digit values of a positive and a negative working word.
   localparam logic [3:0] SIGN_POS = 4'h0;
   localparam logic [3:0] SIGN_NEG = 4'h9;

   // ********
   // Track codes as they reach the block.
   // ********
   // First code as destination, second code as destination.
   localparam logic [1:0] OP_ADD = 2'h0;
   localparam logic [1:0] OP_SUB = 2'h1;
   // First code as source, second code as source.
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_READ_RESET = 2'h3;

   // ********
   // Register map on the bus, byte addresses of aligned words.
   // ********
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_INT_EN = 8'h04;
   localparam logic [7:0] ADDR_INT_CLR = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_SIGN = 8'h10;

   // ********
   // Field positions.
   // ********
   // Event bits, shared by status, enable and clear registers.
   localparam int EV_OVERFLOW = 0;
   localparam int EV_DONE = 1;
   localparam int NUM_EV = 2;
   // Control register: writing one drops the overflow latch.
   localparam int CTRL_DROP = 0;
   // Sign register: negative flags, zero flags, latch and busy.
   localparam int SIGN_NEG_LSB = 0;
   localparam int SIGN_ZERO_LSB = 10;
   localparam int SIGN_OVF_BIT = 20;
   localparam int SIGN_BUSY_BIT = 21;

   // ********
   // Reset values.
   // ********
   localparam logic [1:0] INT_EN_RESET = 2'h0;
   localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;

   // Sequencer states.
   typedef enum logic [1:0] {
      DACC_IDLE = 2'b00,
      DACC_ENTER = 2'b01,
      DACC_READ = 2'b10
   } dacc_state_t;

endpackage

// *** dacc_bcd_add.sv ***
// ********
// Ripple decimal adder, one digit stage per generate step.
// ********
module dacc_bcd_add #(
   parameter int DIGITS = 11
) (
   input wire logic [4*DIGITS-1:0] i_a,
   input wire logic [4*DIGITS-1:0] i_b,
   input wire logic i_cin,
   output logic [4*DIGITS-1:0] o_sum,
   output logic o_cout
);

   // Carry into each digit stage, the last one is the carry out.
   logic [DIGITS:0] carry;

   assign carry[0] = i_cin;
   assign o_cout = carry[DIGITS];

   // Each stage adds two digits and corrects a result above nine.
   genvar g;
   generate
      for (g = 0; g < DIGITS; g = g + 1) begin : g_digit
         logic [4:0] raw;
         logic [4:0] fixed;
         assign raw = {1'b0, i_a[4*g+:4]} + {1'b0, i_b[4*g+:4]} + {4'h0, carry[g]};
         assign fixed = raw + 5'h06;
         assign carry[g+1] = (raw > 5'h09);
         assign o_sum[4*g+:4] = (raw > 5'h09) ? fixed[3:0] : raw[3:0];
      end
   endgenerate

endmodule

// *** dacc_seq_model.sv ***
// ********
// Sequencer and drum transfer path model.
// ********
module dacc_seq_model (
   input wire logic i_clock,
   input wire logic i_rd_valid,
   input wire logic [3:0] i_rd_digit,
   input wire logic i_rd_neg,
   output logic o_start,
   output logic [1:0] o_op,
   output logic o_reset_first,
   output logic [6:0] o_pos,
   output logic o_char_valid,
   output logic [3:0] o_char_digit,
   output logic o_char_neg,
   output logic o_end,
   output logic [39:0] o_rd_val,
   output logic o_rd_mark
);
   timeunit 1ns;
   timeprecision 100ps;

   // Quiet link at time zero.
   initial begin
      o_start = 1'b0;
      o_op = 2'h0;
      o_reset_first = 1'b0;
      o_pos = 7'h00;
      o_char_valid = 1'b0;
      o_char_digit = 4'h0;
      o_char_neg = 1'b0;
      o_end = 1'b0;
   end

   // Read digits arrive low order first, so each lands at the top and shifts down.
   always @(posedge i_clock) begin
      if (i_rd_valid) begin
         o_rd_val <= {i_rd_digit, o_rd_val[39:4]};
         o_rd_mark <= o_rd_mark | i_rd_neg;
      end
   end

   // One instruction; a nonzero gap gives a slow drum, with the idle digit inverted.
   task automatic run(input logic [1:0] op, input logic rf, input logic [6:0] pos,
         input logic [39:0] v, input logic ng, input int n, input int gap);
      @(posedge i_clock);
      o_start <= 1'b1;
      o_op <= op;
      o_reset_first <= rf;
      o_pos <= pos;
      o_rd_val <= '0;
      o_rd_mark <= 1'b0;
      @(posedge i_clock);
      o_start <= 1'b0;
      for (int k = 0; k < n; k++) begin
         o_char_valid <= 1'b1;
         o_char_digit <= v[4*k+:4];
         o_char_neg <= ng && (k == 0);
         @(posedge i_clock);
         if (gap > 0) begin
            o_char_valid <= 1'b0;
            o_char_digit <= ~v[4*k+:4];
            repeat (gap) @(posedge i_clock);
         end
      end
      o_char_valid <= 1'b0;
      o_char_neg <= 1'b0;
      o_end <= 1'b1;
      @(posedge i_clock);
      o_end <= 1'b0;
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
   endtask
endmodule

// *** dacc_track_sva.sv ***
// ********
// Port checker of the accumulator track.
// ********
module dacc_track_chk (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_hsel,
   input wire logic [7:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic i_start,
   input wire logic [1:0] i_op,
   input wire logic i_char_valid,
   input wire logic i_end,
   input wire logic i_overflow_drop,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic o_rd_valid,
   input wire logic o_rd_neg,
   input wire logic o_busy,
   input wire logic o_overflow,
   input wire logic [9:0] o_acc_neg,
   input wire logic [9:0] o_acc_zero
);
   // Readout kind of the running instruction, and the data phase of a control write.
   logic rd_op_reg;
   logic ctrl_ph_reg;
   logic ctrl_take;
   assign ctrl_take = i_hsel && i_htrans[1] && i_hready && i_hwrite
      && (i_haddr == dacc_pkg::ADDR_CTRL);

   // Helper state follows the taken requests.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         rd_op_reg <= 1'b0;
         ctrl_ph_reg <= 1'b0;
      end else begin
         rd_op_reg <= (i_start && !o_busy) ? i_op[1] : rd_op_reg;
         ctrl_ph_reg <= ctrl_take;
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);

   chk_resp_okay: assert property (o_hresp == 1'b0 && o_hreadyout == 1'b1)
      else $error("bus answer not ready okay");
   chk_ovf_hold: assert property (
      o_overflow && !i_overflow_drop && !(ctrl_ph_reg && i_hwdata[0])
      && !$past(i_overflow_drop || (ctrl_ph_reg && i_hwdata[0])) |=> o_overflow)
      else $error("overflow latch fell without drop");
   chk_busy_start: assert property (i_start && !o_busy |-> ##2 o_busy)
      else $error("busy late after start");
   chk_busy_end: assert property (o_busy && i_end |-> ##2 !o_busy)
      else $error("busy held after end");
   chk_rd_step: assert property (o_busy && rd_op_reg && i_char_valid |=> o_rd_valid)
      else $error("read digit late");
   chk_rd_cause: assert property (o_rd_valid |-> $past(i_char_valid) && rd_op_reg)
      else $error("read digit without read step");
   chk_enter_quiet: assert property (
      o_busy && !rd_op_reg && i_char_valid |=> !o_rd_valid)
      else $error("read digit during entry");
   chk_sign_excl: assert property ((o_acc_zero & o_acc_neg) == 10'h000)
      else $error("accumulator both zero and negative");
   chk_mark_digit: assert property (o_rd_neg |-> o_rd_valid)
      else $error("sign mark without digit");
endmodule

bind dacc_track dacc_track_chk u_chk (.*);

// *** dacc_tb.sv ***
// ********
// Self-checking bench of the accumulator track.
// ********
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clock, i_rstn, i_hsel, i_hwrite, i_hready, i_overflow_drop, o_hreadyout, o_hresp;
   logic [7:0] i_haddr;
   logic [1:0] i_htrans, i_op;
   logic [2:0] i_hsize;
   logic [31:0] i_hwdata, o_hrdata, rdat;
   logic i_start, i_reset_first, i_char_valid, i_char_neg, i_end, rd_mark;
   logic [6:0] i_pos;
   logic [3:0] i_char_digit, o_rd_digit;
   logic o_rd_valid, o_rd_neg, o_busy, o_overflow, o_irq;
   logic [9:0] o_acc_neg, o_acc_zero;
   logic [39:0] rd_val;
   int num_errors = 0;
   int comparisons = 0;
   // The single slave's ready is the bus ready.
   assign i_hready = o_hreadyout;

   dacc_track dut (.i_clock, .i_rstn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
      .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_start, .i_op, .i_reset_first,
      .i_pos, .i_char_valid, .i_char_digit, .i_char_neg, .i_end, .i_overflow_drop, .o_rd_valid,
      .o_rd_digit, .o_rd_neg, .o_busy, .o_overflow, .o_acc_neg, .o_acc_zero, .o_irq);
   dacc_seq_model seq (.i_clock, .i_rd_valid(o_rd_valid), .i_rd_digit(o_rd_digit),
      .i_rd_neg(o_rd_neg), .o_start(i_start), .o_op(i_op), .o_reset_first(i_reset_first),
      .o_pos(i_pos), .o_char_valid(i_char_valid), .o_char_digit(i_char_digit),
      .o_char_neg(i_char_neg), .o_end(i_end), .o_rd_val(rd_val), .o_rd_mark(rd_mark));

   // A 25 ns clock.
   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end

   // ********
   // Shared tasks.
   // ********
   // Compare one result; an unknown never matches.
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Print the counts and the verdict, then stop.
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Wait for ready at a rising edge; a hung slave ends the run.
   task automatic wait_rdy;
      int k;
      k = 0;
      @(posedge i_clock);
      while (o_hreadyout !== 1'b1 && k < 50) begin
         k++;
         @(posedge i_clock);
      end
      if (k >= 50) begin
         num_errors++;
         wrap_up;
      end
   endtask

   // One single word transfer; read data lands in rdat.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge i_clock);
      i_hsel <= 1'b1;
      i_htrans <= 2'b10;
      i_haddr <= a;
      i_hwrite <= w;
      wait_rdy;
      i_hsel <= 1'b0;
      i_htrans <= 2'b00;
      i_hwdata <= wd;
      wait_rdy;
      rdat = o_hrdata;
   endtask

   // ********
   // Scenarios.
   // ********
   // Reset values, enable read back, unmapped read, overflow irq enabled.
   task automatic t_regs;
      ahb(1'b0, dacc_pkg::ADDR_STATUS, 32'h0000_0000);
      check(40'(rdat), 40'h00_0000_0000);
      ahb(1'b1, dacc_pkg::ADDR_INT_EN, 32'h0000_0001);
      ahb(1'b0, dacc_pkg::ADDR_INT_EN, 32'h0000_0000);
      check(40'(rdat), 40'h00_0000_0001);
      ahb(1'b0, 8'h40, 32'h0000_0000);
      check(40'(rdat), 40'h00_0000_0000);
      ahb(1'b0, dacc_pkg::ADDR_SIGN, 32'h0000_0000);
      check(40'(rdat), 40'h00_000f_fc00);
   endtask

   // Add into accumulator 2, then read it twice, promptly and slowly.
   task automatic t_add_read;
      seq.run(dacc_pkg::OP_ADD, 1'b0, 7'h1d, 40'h00_0012_3456, 1'b0, 10, 0);
      seq.run(dacc_pkg::OP_READ, 1'b0, 7'h1d, 40'h00_0000_0000, 1'b0, 10, 0);
      check(rd_val, 40'h00_0012_3456);
      seq.run(dacc_pkg::OP_READ, 1'b0, 7'h1d, 40'h00_0000_0000, 1'b0, 10, 2);
      check(rd_val, 40'h00_0012_3456);
      check(40'({o_acc_neg[2], o_acc_zero[2], rd_mark}), 40'h00_0000_0000);
   endtask

   // A negative operand added drives the sum negative; readout-reset shows the magnitude.
   task automatic t_neg;
      seq.run(dacc_pkg::OP_ADD, 1'b0, 7'h1d, 40'h00_0100_0000, 1'b1, 10, 0);
      check(40'(o_acc_neg[2]), 40'h00_0000_0001);
      seq.run(dacc_pkg::OP_READ_RESET, 1'b0, 7'h1d, 40'h00_0000_0000, 1'b0, 10, 0);
      check(rd_val, 40'h00_0087_6544);
      check(40'(rd_mark), 40'h00_0000_0001);
      check(40'({o_acc_neg[2], o_acc_zero[2]}), 40'h00_0000_0001);
   endtask

   // Entry two places left of units, then a reset-subtract.
   task automatic t_shift;
      seq.run(dacc_pkg::OP_ADD, 1'b0, 7'h1b, 40'h00_0000_0005, 1'b0, 1, 0);
      seq.run(dacc_pkg::OP_READ, 1'b0, 7'h1d, 40'h00_0000_0000, 1'b0, 10, 0);
      check(rd_val, 40'h00_0000_0500);
      seq.run(dacc_pkg::OP_SUB, 1'b1, 7'h1d, 40'h00_0000_0003, 1'b0, 1, 0);
      seq.run(dacc_pkg::OP_READ_RESET, 1'b0, 7'h1d, 40'h00_0000_0000, 1'b0, 10, 0);
      check(rd_val, 40'h00_0000_0003);
      check(40'(rd_mark), 40'h00_0000_0001);
   endtask

   // Readout-reset across accumulators 5 and 4, half of each read.
   task automatic t_multi;
      seq.run(dacc_pkg::OP_ADD, 1'b0, 7'h31, 40'h98_7654_3210, 1'b0, 10, 0);
      seq.run(dacc_pkg::OP_ADD, 1'b0, 7'h3b, 40'h11_1111_1111, 1'b0, 10, 0);
      seq.run(dacc_pkg::OP_READ_RESET, 1'b0, 7'h36, 40'h00_0000_0000, 1'b0, 10, 0);
      check(rd_val, 40'h43_2101_1111);
      check(40'(o_acc_zero[5:4]), 40'h00_0000_0003);
   endtask

   // Overflow of accumulator 3, latch, interrupt, drop and clear.
   task automatic t_ovf;
      seq.run(dacc_pkg::OP_ADD, 1'b0, 7'h27, 40'h99_9999_9999, 1'b0, 10, 0);
      seq.run(dacc_pkg::OP_ADD, 1'b0, 7'h27, 40'h99_9999_9999, 1'b0, 10, 0);
      check(40'({o_overflow, o_irq}), 40'h00_0000_0003);
      check(40'(o_acc_zero[4]), 40'h00_0000_0001);
      ahb(1'b0, dacc_pkg::ADDR_STATUS, 32'h0000_0000);
      check(40'(rdat), 40'h00_0000_0003);
      ahb(1'b1, dacc_pkg::ADDR_CTRL, 32'h0000_0001);
      ahb(1'b0, dacc_pkg::ADDR_SIGN, 32'h0000_0000);
      check(40'(rdat[21:20]), 40'h00_0000_0000);
      ahb(1'b1, dacc_pkg::ADDR_INT_CLR, 32'h0000_0003);
      ahb(1'b0, dacc_pkg::ADDR_STATUS, 32'h0000_0000);
      check(40'({rdat[1:0], o_irq}), 40'h00_0000_0000);
   endtask

   // Reset for three cycles, then the scenarios in turn.
   initial begin
      i_rstn = 1'b0;
      i_hsel = 1'b0;
      i_haddr = 8'h00;
      i_htrans = 2'b00;
      i_hwrite = 1'b0;
      i_hsize = 3'h2;
      i_hwdata = 32'h0000_0000;
      i_overflow_drop = 1'b0;
      repeat (3) @(posedge i_clock);
      i_rstn <= 1'b1;
      t_regs;
      t_add_read;
      t_neg;
      t_shift;
      t_multi;
      t_ovf;
      wrap_up;
   end
endmodule
